// ### rtl/sps_params.svh
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
`define SPS_STAGES 8
`define SPS_FIRST_STAGE 0
`define SPS_ZERO_WORD 8'h00
`endif

// ### rtl/sps_pkg.sv
`include "sps_params.svh"
package sps_pkg;
   typedef logic [`SPS_STAGES-1:0] sps_word_t;
   typedef enum logic [2:0] {
      SPS_IDLE = 3'b001,
      SPS_SHIFT = 3'b010,
      SPS_LOAD = 3'b100
   } sps_state_t;
endpackage : sps_pkg

// ### rtl/sps_if.sv
`timescale 1ns/1ps
`include "sps_params.svh"
interface sps_if;
   logic serial_data_in;
   logic shift_clock;
   logic shift_clear_n;
   logic storage_clock;
   logic output_enable_n;
   logic [`SPS_STAGES-1:0] parallel_outputs;
   logic [`SPS_STAGES-1:0] parallel_outputs_oe;
   logic cascade_serial_out;
   modport device (
      input serial_data_in, shift_clock, shift_clear_n, storage_clock, output_enable_n,
      output parallel_outputs, parallel_outputs_oe, cascade_serial_out
   );
   modport host (
      output serial_data_in, shift_clock, shift_clear_n, storage_clock, output_enable_n,
      input parallel_outputs, parallel_outputs_oe, cascade_serial_out
   );
endinterface : sps_if

// ### rtl/sps_device.sv
// Function
// [R1] Output enable high floats outputs, registers untouched.
// [R2] Clear low holds all shift stages zero.
// [R3] Shift edge moves data one stage up.
// [R4] Storage edge copies shift stages to storage; the code skips the copy while clear is low.
// [R5] Coincident edges store old contents, then shift.
// [R6] Last stage drives the cascade serial output.
// [R7] Controller clears then pulses storage after power-up.
// [R8] Controller may modulate or tie output enable.
// [R9] Storage holds its pattern while shifting continues.
// [R10] Registers start unknown; no reset default assumed.
// [R11] Eight stages; first maps output zero, last seven.
`timescale 1ns/1ps
`include "sps_params.svh"
module sps_device #(
   parameter int STAGES = `SPS_STAGES
) (
   input wire logic mclk,
   input wire logic reset,
   sps_if.device pins
);
   logic [2:0] sdi_sync_reg, sdi_sync_next;
   logic [2:0] sck_sync_reg, sck_sync_next;
   logic [2:0] clr_sync_reg, clr_sync_next;
   logic [2:0] stc_sync_reg, stc_sync_next;
   logic [2:0] oen_sync_reg, oen_sync_next;
   logic sdi_reg, sdi_next;
   logic sck_reg, sck_next;
   logic clr_n_reg, clr_n_next;
   logic stc_reg, stc_next;
   logic oen_reg, oen_next;
   logic [STAGES-1:0] shift_reg, shift_next;
   logic [STAGES-1:0] store_reg, store_next;
   logic sck_rise;
   logic stc_rise;

   // Pins are asynchronous to mclk; a level counts once stages two and three agree.
   always_comb begin
      sdi_sync_next = {sdi_sync_reg[1:0], pins.serial_data_in};
      sck_sync_next = {sck_sync_reg[1:0], pins.shift_clock};
      clr_sync_next = {clr_sync_reg[1:0], pins.shift_clear_n};
      stc_sync_next = {stc_sync_reg[1:0], pins.storage_clock};
      oen_sync_next = {oen_sync_reg[1:0], pins.output_enable_n};
      sdi_next = (sdi_sync_reg[2] == sdi_sync_reg[1]) ? sdi_sync_reg[2] : sdi_reg;
      sck_next = (sck_sync_reg[2] == sck_sync_reg[1]) ? sck_sync_reg[2] : sck_reg;
      clr_n_next = (clr_sync_reg[2] == clr_sync_reg[1]) ? clr_sync_reg[2] : clr_n_reg;
      stc_next = (stc_sync_reg[2] == stc_sync_reg[1]) ? stc_sync_reg[2] : stc_reg;
      oen_next = (oen_sync_reg[2] == oen_sync_reg[1]) ? oen_sync_reg[2] : oen_reg;
   end

   always_ff @(posedge mclk) begin
      sdi_sync_reg <= sdi_sync_next;
      sck_sync_reg <= sck_sync_next;
      clr_sync_reg <= clr_sync_next;
      stc_sync_reg <= stc_sync_next;
      oen_sync_reg <= oen_sync_next;
      if (reset) begin
         sdi_reg <= 1'b0;
         sck_reg <= 1'b0;
         clr_n_reg <= 1'b1;
         stc_reg <= 1'b0;
         oen_reg <= 1'b1;
      end else begin
         sdi_reg <= sdi_next;
         sck_reg <= sck_next;
         clr_n_reg <= clr_n_next;
         stc_reg <= stc_next;
         oen_reg <= oen_next;
      end
   end

   assign sck_rise = sck_next & ~sck_reg;
   assign stc_rise = stc_next & ~stc_reg;

   // The data registers take no reset, so the device powers up unknown as the real part does. see [R10]
   always_comb begin
      shift_next = shift_reg;
      store_next = store_reg;
      if (stc_rise && clr_n_next) begin
         store_next = shift_reg; // see [R4] see [R5]
      end
      if (!clr_n_next) begin
         shift_next = `SPS_ZERO_WORD; // see [R2]
      end else if (sck_rise) begin
         shift_next = {shift_reg[STAGES-2:0], sdi_next}; // see [R3] see [R11]
      end
   end

   always_ff @(posedge mclk) begin
      shift_reg <= shift_next;
      store_reg <= store_next; // see [R9]
   end

   assign pins.parallel_outputs = store_reg; // see [R11]
   assign pins.parallel_outputs_oe = {STAGES{~oen_reg}}; // see [R1]
   assign pins.cascade_serial_out = shift_reg[STAGES-1]; // see [R6]
endmodule : sps_device

// ### rtl/sps_host.sv
`timescale 1ns/1ps
`include "sps_params.svh"
module sps_host #(
   parameter int STAGES = `SPS_STAGES,
   parameter int HALF_PERIOD = 4
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [STAGES-1:0] load_data,
   input wire logic load_valid,
   output logic load_ready,
   input wire logic init_req,
   input wire logic blank_n,
   sps_if.host pins
);
   sps_pkg::sps_state_t state_reg, state_next;
   logic [STAGES-1:0] data_reg, data_next;
   logic [7:0] div_reg, div_next;
   logic [4:0] bit_reg, bit_next;
   logic phase_reg, phase_next;
   logic clear_reg, clear_next;
   logic sdi_reg, sdi_next;
   logic sck_reg, sck_next;
   logic stc_reg, stc_next;
   logic tick;

   assign tick = (div_reg == 8'(HALF_PERIOD - 1));

   // Init drives clear low and then pulses storage, giving all-zero outputs.
   always_comb begin
      state_next = state_reg;
      data_next = data_reg;
      div_next = tick ? 8'h00 : div_reg + 8'h01;
      bit_next = bit_reg;
      phase_next = phase_reg;
      clear_next = clear_reg;
      sdi_next = sdi_reg;
      sck_next = sck_reg;
      stc_next = stc_reg;
      unique case (state_reg)
         sps_pkg::SPS_IDLE: begin
            if (init_req) begin
               clear_next = 1'b1; // see [R7]
               state_next = sps_pkg::SPS_LOAD;
               phase_next = 1'b0;
            end else if (load_valid) begin
               data_next = load_data;
               bit_next = 5'h00;
               phase_next = 1'b0;
               state_next = sps_pkg::SPS_SHIFT;
            end
         end
         sps_pkg::SPS_SHIFT: begin
            if (tick) begin
               if (!phase_reg) begin
                  sdi_next = data_reg[STAGES-1];
                  sck_next = 1'b0;
                  phase_next = 1'b1;
               end else begin
                  sck_next = 1'b1;
                  data_next = {data_reg[STAGES-2:0], 1'b0};
                  phase_next = 1'b0;
                  bit_next = bit_reg + 5'h01;
                  if (bit_reg == 5'(STAGES - 1)) begin
                     state_next = sps_pkg::SPS_LOAD;
                  end
               end
            end
         end
         sps_pkg::SPS_LOAD: begin
            if (tick) begin
               if (!phase_reg) begin
                  sck_next = 1'b0;
                  stc_next = 1'b0;
                  phase_next = 1'b1;
               end else begin
                  stc_next = 1'b1; // see [R9]
                  phase_next = 1'b0;
                  clear_next = 1'b0;
                  state_next = sps_pkg::SPS_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg <= sps_pkg::SPS_IDLE;
         data_reg <= `SPS_ZERO_WORD;
         div_reg <= 8'h00;
         bit_reg <= 5'h00;
         phase_reg <= 1'b0;
         clear_reg <= 1'b0;
         sdi_reg <= 1'b0;
         sck_reg <= 1'b0;
         stc_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         data_reg <= data_next;
         div_reg <= div_next;
         bit_reg <= bit_next;
         phase_reg <= phase_next;
         clear_reg <= clear_next;
         sdi_reg <= sdi_next;
         sck_reg <= sck_next;
         stc_reg <= stc_next;
      end
   end

   assign load_ready = (state_reg == sps_pkg::SPS_IDLE) && !init_req;
   assign pins.serial_data_in = sdi_reg; // see [R6]
   assign pins.shift_clock = sck_reg;
   assign pins.shift_clear_n = ~clear_reg;
   assign pins.storage_clock = stc_reg;
   assign pins.output_enable_n = ~blank_n; // see [R8]
endmodule : sps_host

// ### verif/sps_checker.sv
`timescale 1ns/1ps
module sps_checker (
   input wire logic mclk,
   input wire logic reset,
   input wire logic shift_clock,
   input wire logic shift_clear_n,
   input wire logic storage_clock,
   input wire logic output_enable_n,
   input wire sps_pkg::sps_word_t parallel_outputs,
   input wire sps_pkg::sps_word_t parallel_outputs_oe,
   input wire logic cascade_serial_out
);
   // Pins cross a resynchroniser, so a cause is looked for three to six cycles back.
   logic [5:0] sck_reg;
   logic [5:0] stc_reg;
   logic [5:0] clr_reg;
   always_ff @(posedge mclk) begin
      sck_reg <= {sck_reg[4:0], shift_clock};
      stc_reg <= {stc_reg[4:0], storage_clock};
      clr_reg <= {clr_reg[4:0], !shift_clear_n};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence store_seen; |stc_reg[5:2]; endsequence
   sequence cause_seen; (|sck_reg[5:2]) || (|clr_reg[5:2]); endsequence
   oe_follow_a: assert property ($stable(output_enable_n) [*7] |->
      parallel_outputs_oe == {8{!output_enable_n}}) else $error("enable mismatch");
   oe_uniform_a: assert property (parallel_outputs_oe == {8{parallel_outputs_oe[0]}})
      else $error("enables differ");
   oe_isolated_a: assert property ($changed(parallel_outputs_oe) |-> $stable(parallel_outputs))
      else $error("enable moved data");
   store_hold_a: assert property ($changed(parallel_outputs) |-> store_seen)
      else $error("outputs moved");
   store_copy_a: assert property ($rose(storage_clock) && shift_clear_n |-> ##6
      parallel_outputs[7] == cascade_serial_out) else $error("store copy wrong");
   cascade_cause_a: assert property ($changed(cascade_serial_out) |-> cause_seen)
      else $error("cascade moved");
   clear_zero_a: assert property (!shift_clear_n [*6] |-> !cascade_serial_out)
      else $error("clear ignored");
   init_order_a: assert property ($rose(shift_clear_n) |-> storage_clock)
      else $error("clear released early");
endmodule : sps_checker

// ### verif/tb_serial_in_parallel_out_shifter.sv
`timescale 1ns/1ps
module tb_serial_in_parallel_out_shifter;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic load_valid = 1'b0;
   logic init_req = 1'b0;
   logic blank_n = 1'b1;
   logic load_ready;
   sps_pkg::sps_word_t load_data = 8'h00;
   sps_pkg::sps_word_t held;
   int fail_count = 0;
   int samples_checked = 0;
   sps_if sps_if_inst ();
   sps_host sps_host_inst (.mclk(mclk), .reset(reset), .load_data(load_data), .load_valid(load_valid),
      .load_ready(load_ready), .init_req(init_req), .blank_n(blank_n), .pins(sps_if_inst.host));
   sps_device sps_device_inst (.mclk(mclk), .reset(reset), .pins(sps_if_inst.device));
   sps_checker sps_checker_inst (.mclk(mclk), .reset(reset), .shift_clock(sps_if_inst.shift_clock),
      .shift_clear_n(sps_if_inst.shift_clear_n), .storage_clock(sps_if_inst.storage_clock),
      .output_enable_n(sps_if_inst.output_enable_n), .parallel_outputs(sps_if_inst.parallel_outputs),
      .parallel_outputs_oe(sps_if_inst.parallel_outputs_oe), .cascade_serial_out(sps_if_inst.cascade_serial_out));
   initial begin
      forever #2 mclk = ~mclk;
   end
   task automatic finish_test();
      $display("checked %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic check(input sps_pkg::sps_word_t exp, input sps_pkg::sps_word_t got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask : check
   // Storage only moves after ready returns, so the old pattern is checked every busy cycle of a run without init.
   task automatic run(input logic init, input sps_pkg::sps_word_t word);
      int n;
      n = 0;
      load_data = word;
      load_valid = !init;
      init_req = init;
      @(negedge mclk);
      load_valid = 1'b0;
      init_req = 1'b0;
      while (load_ready !== 1'b1) begin
         if (!init) check(held, sps_if_inst.parallel_outputs);
         @(negedge mclk);
         n++;
         if (n > 300) begin
            fail_count++;
            finish_test();
         end
      end
      repeat (8) @(negedge mclk);
      held = init ? 8'h00 : word;
      check(held, sps_if_inst.parallel_outputs);
      check({7'h00, held[7]}, {7'h00, sps_if_inst.cascade_serial_out});
   endtask : run
   task automatic scen_patterns();
      sps_pkg::sps_word_t pats [6] = '{8'ha5, 8'h5a, 8'h01, 8'h80, 8'hff, 8'h00};
      foreach (pats[i]) run(1'b0, pats[i]);
   endtask : scen_patterns
   task automatic scen_blank();
      blank_n = 1'b0;
      repeat (8) @(negedge mclk);
      check(8'h00, sps_if_inst.parallel_outputs_oe);
      check(held, sps_if_inst.parallel_outputs);
      blank_n = 1'b1;
      repeat (8) @(negedge mclk);
      check(8'hff, sps_if_inst.parallel_outputs_oe);
   endtask : scen_blank
   task automatic scen_reinit();
      run(1'b0, 8'h3c);
      run(1'b1, 8'h00);
   endtask : scen_reinit
   initial begin
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      run(1'b1, 8'h00);
      scen_patterns();
      run(1'b0, 8'hc3);
      scen_blank();
      scen_reinit();
      finish_test();
   end
endmodule : tb_serial_in_parallel_out_shifter
